// file: rtl/smi_pkg.sv
package smi_pkg;
  // clock and timing figures
  localparam int unsigned CLK_KHZ        = 50000;
  localparam int unsigned ES_INTERVAL_MS = 1000;
  localparam int unsigned ES_CYCLES      = ES_INTERVAL_MS * CLK_KHZ;
  localparam int unsigned FLASH_MS       = 100;
  localparam int unsigned FLASH_CYCLES   = FLASH_MS * CLK_KHZ;
  localparam int unsigned FRAME_LEN_DEF  = 64;
  localparam int unsigned CNT_W_DEF      = 24;

  // byte positions inside a frame
  localparam int unsigned POS_A1 = 0;
  localparam int unsigned POS_A2 = 1;
  localparam int unsigned POS_J0 = 2;
  localparam int unsigned POS_B1 = 3;
  localparam int unsigned POS_D7 = 4;
  localparam int unsigned POS_D8 = 5;
  localparam int unsigned POS_D9 = 6;
  localparam int unsigned POS_B2 = 7;
  localparam int unsigned POS_M1 = 8;
  localparam int unsigned POS_PL = 9;

  // overhead values, injection masks and reset values
  localparam logic [7:0]  A1_VAL      = 8'hF6;
  localparam logic [7:0]  A2_VAL      = 8'h28;
  localparam logic [7:0]  J0_PASS_VAL = 8'h01;
  localparam logic [31:0] TX_OH_RST   = 32'h0000_0000;
  localparam logic [31:0] CFG_RST     = 32'h0000_0000;
  localparam logic [7:0]  B1_INJ_MASK = 8'h01;
  localparam logic [7:0]  B2_INJ_MASK = 8'h03;
  localparam logic [7:0]  REI_INJ_VAL = 8'h01;
  localparam logic [7:0]  REI_MAX     = 8'h08;
  localparam logic [15:0] RAND_THRESH = 16'h020C;
  localparam logic [22:0] PRBS_SEED   = 23'h7FFFFF;
  localparam logic [31:0] RNG_SEED    = 32'hACE1_2468;
  localparam logic [31:0] RNG_POLY    = 32'h04C1_1DB7;

  // register byte offsets
  localparam logic [7:0] OFF_CMD    = 8'h00;
  localparam logic [7:0] OFF_CFG    = 8'h04;
  localparam logic [7:0] OFF_TX_OH  = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0C;
  localparam logic [7:0] OFF_RX_OH1 = 8'h10;
  localparam logic [7:0] OFF_RX_OH2 = 8'h14;
  localparam logic [7:0] OFF_B1_TOT = 8'h18;
  localparam logic [7:0] OFF_B1_ES  = 8'h1C;
  localparam logic [7:0] OFF_B2_TOT = 8'h20;
  localparam logic [7:0] OFF_B2_ES  = 8'h24;
  localparam logic [7:0] OFF_REI_TOT = 8'h28;
  localparam logic [7:0] OFF_REI_ES = 8'h2C;
  localparam logic [7:0] OFF_PRBS_TOT = 8'h30;
  localparam logic [7:0] OFF_B2_BITS = 8'h34;

  // command bits (write one to act)
  localparam int unsigned CMD_RUN_TGL   = 0;
  localparam int unsigned CMD_PAUSE_TGL = 1;
  localparam int unsigned CMD_INJ_B1    = 2;
  localparam int unsigned CMD_INJ_B2    = 3;
  localparam int unsigned CMD_INJ_REI   = 4;
  // configuration bits
  localparam int unsigned CFG_TX_PRBS = 0;
  localparam int unsigned CFG_RX_PRBS = 1;
  localparam int unsigned CFG_J0_SET  = 2;
  localparam int unsigned CFG_RAND    = 3;
endpackage : smi_pkg

// file: rtl/smi_stm16_error_inject_monitor.sv
`timescale 1ns/1ps
module smi_stm16_error_inject_monitor #(
  parameter int unsigned FRAME_LEN = smi_pkg::FRAME_LEN_DEF,
  parameter int unsigned CNT_W     = smi_pkg::CNT_W_DEF,
  parameter int unsigned ES_CYC    = smi_pkg::ES_CYCLES,
  parameter int unsigned FLASH_CYC = smi_pkg::FLASH_CYCLES
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        link_clk,
  input  wire logic [7:0]  rx_data,
  output logic      [7:0]  tx_data,
  output logic             inj_active_led,
  output logic             b1_led,
  output logic             b2_led,
  output logic             rei_led,
  output logic             run_led,
  output logic             pause_led
);
  import smi_pkg::*;

  localparam int unsigned POS_W = $clog2(FRAME_LEN);
  localparam logic [POS_W-1:0] LAST_POS = POS_W'(FRAME_LEN - 1);
  localparam logic [31:0] B2_BITS_FRM = 32'(8 * (FRAME_LEN - POS_D7));

  // refuse sizes the byte map and counters cannot hold
  if (FRAME_LEN < 16 || FRAME_LEN > 4096) $error("FRAME_LEN out of range");
  if (CNT_W < 8 || CNT_W > 32) $error("CNT_W out of range");
  if (ES_CYC < 2 || FLASH_CYC < 2) $error("interval too short");

  function automatic logic [3:0] popcnt8(input logic [7:0] v);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < 8; i++)
      n = n + {3'h0, v[i]};
    return n;
  endfunction : popcnt8

  // eight steps of x^23 + x^18 + 1, newest bit in bit 0
  function automatic logic [22:0] prbs_next8(input logic [22:0] s);
    logic [22:0] r;
    r = s;
    for (int i = 0; i < 8; i++)
      r = {r[21:0], r[22] ^ r[17]};
    return r;
  endfunction : prbs_next8

  // saturating add; top bit reports overflow
  function automatic logic [CNT_W:0] sat_add(input logic [CNT_W-1:0] c, input logic [3:0] n);
    logic [CNT_W:0] s;
    s = {1'b0, c} + (CNT_W+1)'(n);
    if (s[CNT_W])
      s = {1'b1, {CNT_W{1'b1}}};
    return s;
  endfunction : sat_add

  // link clock and receive byte synchronisers
  logic [2:0] lclk_q;
  logic [7:0] rx_s1_q;
  logic [7:0] rx_s2_q;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      lclk_q  <= 3'h0;
      rx_s1_q <= 8'h00;
      rx_s2_q <= 8'h00;
    end
    else
    begin
      lclk_q  <= {lclk_q[1:0], link_clk};
      rx_s1_q <= rx_data;
      rx_s2_q <= rx_s1_q;
    end
  end
  wire byte_stb = lclk_q[1] & ~lclk_q[2];

  // bus slave: zero wait state, registered read data
  logic        wr_pend_q;
  logic [7:0]  wr_addr_q;
  logic [31:0] cfg_q;
  logic [31:0] tx_oh_q;
  logic        run_q;
  logic        pause_q;
  wire         bus_acc = hsel & htrans[1] & hready;
  wire         cmd_wr  = wr_pend_q && (wr_addr_q == OFF_CMD);
  wire [4:0]   cmd     = cmd_wr ? hwdata[4:0] : 5'h00;
  wire         clr     = cmd[CMD_RUN_TGL] & ~run_q;
  wire         cnt_en  = run_q & ~pause_q;
  logic [31:0] rd_mux;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
      cfg_q     <= CFG_RST;
      tx_oh_q   <= TX_OH_RST;
      run_q     <= 1'b0;
      pause_q   <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      wr_pend_q <= bus_acc & hwrite;
      wr_addr_q <= haddr[7:0];
      if (bus_acc && !hwrite)
        hrdata <= rd_mux;
      if (wr_pend_q && wr_addr_q == OFF_CFG)
        cfg_q <= hwdata;
      if (wr_pend_q && wr_addr_q == OFF_TX_OH)
        tx_oh_q <= hwdata;
      if (cmd[CMD_RUN_TGL])
        run_q <= ~run_q;
      if (cmd[CMD_PAUSE_TGL])
        pause_q <= ~pause_q;
    end
  end

  // transmit byte path
  logic [POS_W-1:0] tx_pos_q;
  logic [7:0]  tx_b1_acc_q;
  logic [7:0]  tx_b2_acc_q;
  logic [7:0]  tx_b1_q;
  logic [7:0]  tx_b2_q;
  logic [22:0] tx_prbs_q;
  logic [31:0] rng_q;
  logic        pend_b1_q;
  logic        pend_b2_q;
  logic        pend_rei_q;
  wire  [22:0] tx_prbs_nx = prbs_next8(tx_prbs_q);
  wire         tx_pl      = tx_pos_q >= POS_W'(POS_PL);
  wire         tx_in_b2   = tx_pos_q >= POS_W'(POS_D7);
  wire  [7:0]  tx_j0      = cfg_q[CFG_J0_SET] ? tx_oh_q[7:0] : J0_PASS_VAL;
  wire  [7:0]  tx_raw     =
    (tx_pos_q == POS_W'(POS_A1)) ? A1_VAL :
    (tx_pos_q == POS_W'(POS_A2)) ? A2_VAL :
    (tx_pos_q == POS_W'(POS_J0)) ? tx_j0 :
    (tx_pos_q == POS_W'(POS_B1)) ? (pend_b1_q ? tx_b1_q ^ B1_INJ_MASK : tx_b1_q) :
    (tx_pos_q == POS_W'(POS_D7)) ? tx_oh_q[15:8] :
    (tx_pos_q == POS_W'(POS_D8)) ? tx_oh_q[23:16] :
    (tx_pos_q == POS_W'(POS_D9)) ? tx_oh_q[31:24] :
    (tx_pos_q == POS_W'(POS_B2)) ? (pend_b2_q ? tx_b2_q ^ B2_INJ_MASK : tx_b2_q) :
    (tx_pos_q == POS_W'(POS_M1)) ? (pend_rei_q ? REI_INJ_VAL : 8'h00) :
    (cfg_q[CFG_TX_PRBS] ? tx_prbs_nx[7:0] : 8'h00);
  // random hits spare the framing bytes so the analyzer keeps alignment
  wire         rand_hit   = cfg_q[CFG_RAND] && rng_q[15:0] < RAND_THRESH &&
                            tx_pos_q > POS_W'(POS_A2);
  wire  [7:0]  rand_mask  = rand_hit ? (8'h01 << rng_q[18:16]) : 8'h00;
  wire         tx_last    = tx_pos_q == LAST_POS;
  wire  [7:0]  tx_b1_nx   = tx_b1_acc_q ^ tx_raw;
  wire  [7:0]  tx_b2_nx   = tx_in_b2 ? tx_b2_acc_q ^ tx_raw : tx_b2_acc_q;

  // parity covers the sent frame before random hits, so those show at the far end
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      tx_pos_q    <= '0;
      tx_b1_acc_q <= 8'h00;
      tx_b2_acc_q <= 8'h00;
      tx_b1_q     <= 8'h00;
      tx_b2_q     <= 8'h00;
      tx_prbs_q   <= PRBS_SEED;
      rng_q       <= RNG_SEED;
      pend_b1_q   <= 1'b0;
      pend_b2_q   <= 1'b0;
      pend_rei_q  <= 1'b0;
      tx_data     <= 8'h00;
    end
    else
    begin
      rng_q <= {rng_q[30:0], 1'b0} ^ (rng_q[31] ? RNG_POLY : 32'h0000_0000);
      if (byte_stb)
      begin
        tx_data     <= tx_raw ^ rand_mask;
        tx_pos_q    <= tx_last ? '0 : tx_pos_q + 1'b1;
        tx_b1_acc_q <= tx_last ? 8'h00 : tx_b1_nx;
        tx_b2_acc_q <= tx_last ? 8'h00 : tx_b2_nx;
        if (tx_last)
        begin
          tx_b1_q <= tx_b1_nx;
          tx_b2_q <= tx_b2_nx;
        end
        if (tx_pl && cfg_q[CFG_TX_PRBS])
          tx_prbs_q <= tx_prbs_nx;
      end
      // a request in the cycle its byte goes out is kept for the next frame
      pend_b1_q  <= cmd[CMD_INJ_B1] | (pend_b1_q & ~(byte_stb && tx_pos_q == POS_W'(POS_B1)));
      pend_b2_q  <= cmd[CMD_INJ_B2] | (pend_b2_q & ~(byte_stb && tx_pos_q == POS_W'(POS_B2)));
      pend_rei_q <= cmd[CMD_INJ_REI] | (pend_rei_q & ~(byte_stb && tx_pos_q == POS_W'(POS_M1)));
    end
  end

  // receive framing, overhead capture and parity check
  logic [POS_W-1:0] rx_pos_q;
  logic        locked_q;
  logic        ref_ok_q;
  logic [7:0]  rx_prev_q;
  logic [7:0]  rx_b1_acc_q;
  logic [7:0]  rx_b2_acc_q;
  logic [7:0]  rx_b1_ref_q;
  logic [7:0]  rx_b2_ref_q;
  logic [22:0] rx_prbs_q;
  logic [23:0] rx_oh1_q;
  logic [23:0] rx_oh2_q;
  wire  [22:0] rx_prbs_nx = prbs_next8(rx_prbs_q);
  wire         rx_last    = rx_pos_q == LAST_POS;
  wire         rx_chk     = byte_stb & locked_q & ref_ok_q;
  wire  [7:0]  rei_val    = (rx_s2_q > REI_MAX) ? REI_MAX : rx_s2_q;
  wire  [3:0]  inc [3];
  assign inc[0] = (rx_chk && rx_pos_q == POS_W'(POS_B1)) ? popcnt8(rx_s2_q ^ rx_b1_ref_q) : 4'h0;
  assign inc[1] = (rx_chk && rx_pos_q == POS_W'(POS_B2)) ? popcnt8(rx_s2_q ^ rx_b2_ref_q) : 4'h0;
  assign inc[2] = (rx_chk && rx_pos_q == POS_W'(POS_M1)) ? rei_val[3:0] : 4'h0;
  wire  [3:0]  prbs_inc   = (byte_stb && locked_q && cfg_q[CFG_RX_PRBS] && rx_pos_q >= POS_W'(POS_PL)) ?
                            popcnt8(rx_s2_q ^ rx_prbs_nx[7:0]) : 4'h0;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rx_pos_q    <= '0;
      locked_q    <= 1'b0;
      ref_ok_q    <= 1'b0;
      rx_prev_q   <= 8'h00;
      rx_b1_acc_q <= 8'h00;
      rx_b2_acc_q <= 8'h00;
      rx_b1_ref_q <= 8'h00;
      rx_b2_ref_q <= 8'h00;
      rx_prbs_q   <= PRBS_SEED;
      rx_oh1_q    <= 24'h000000;
      rx_oh2_q    <= 24'h000000;
    end
    else if (byte_stb)
    begin
      rx_prev_q <= rx_s2_q;
      rx_prbs_q <= (locked_q && rx_pos_q >= POS_W'(POS_PL)) ? {rx_prbs_q[14:0], rx_s2_q} : rx_prbs_q; // payload only
      if (!locked_q)
      begin
        ref_ok_q <= 1'b0;
        if (rx_prev_q == A1_VAL && rx_s2_q == A2_VAL)
        begin
          locked_q    <= 1'b1;
          rx_pos_q    <= POS_W'(POS_J0);
          rx_b1_acc_q <= A1_VAL ^ A2_VAL;
          rx_b2_acc_q <= 8'h00;
          rx_oh1_q[15:0] <= {A2_VAL, A1_VAL};
        end
      end
      else
      begin
        if ((rx_pos_q == POS_W'(POS_A1) && rx_s2_q != A1_VAL) ||
            (rx_pos_q == POS_W'(POS_A2) && rx_s2_q != A2_VAL))
          locked_q <= 1'b0;
        rx_pos_q    <= rx_last ? '0 : rx_pos_q + 1'b1;
        rx_b1_acc_q <= rx_last ? 8'h00 : rx_b1_acc_q ^ rx_s2_q;
        rx_b2_acc_q <= rx_last ? 8'h00 :
                       (rx_pos_q >= POS_W'(POS_D7)) ? rx_b2_acc_q ^ rx_s2_q : rx_b2_acc_q;
        if (rx_last)
        begin
          rx_b1_ref_q <= rx_b1_acc_q ^ rx_s2_q;
          rx_b2_ref_q <= rx_b2_acc_q ^ rx_s2_q;
          ref_ok_q    <= 1'b1;
        end
        if (rx_pos_q == POS_W'(POS_A1))
          rx_oh1_q[7:0] <= rx_s2_q;
        if (rx_pos_q == POS_W'(POS_A2))
          rx_oh1_q[15:8] <= rx_s2_q;
        if (rx_pos_q == POS_W'(POS_J0))
          rx_oh1_q[23:16] <= rx_s2_q;
        if (rx_pos_q == POS_W'(POS_D7))
          rx_oh2_q[7:0] <= rx_s2_q;
        if (rx_pos_q == POS_W'(POS_D8))
          rx_oh2_q[15:8] <= rx_s2_q;
        if (rx_pos_q == POS_W'(POS_D9))
          rx_oh2_q[23:16] <= rx_s2_q;
      end
    end
  end

  // error counters, errored seconds, overflow and status lights
  logic [CNT_W-1:0] tot_q [3];
  logic [CNT_W-1:0] es_q [3];
  logic [2:0]       ovf_q;
  logic [2:0]       sec_err_q;
  logic [31:0]      sec_cnt_q;
  logic [31:0]      flash_q [3];
  logic [2:0]       led_q;
  logic [CNT_W-1:0] prbs_tot_q;
  logic [31:0]      b2_bits_q;
  wire              sec_tick = cnt_en && (sec_cnt_q == ES_CYC - 1);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      for (int t = 0; t < 3; t++)
      begin
        tot_q[t]   <= '0;
        es_q[t]    <= '0;
        flash_q[t] <= 32'h0000_0000;
      end
      ovf_q      <= 3'h0;
      sec_err_q  <= 3'h0;
      sec_cnt_q  <= 32'h0000_0000;
      led_q      <= 3'h0;
      prbs_tot_q <= '0;
      b2_bits_q  <= 32'h0000_0000;
      inj_active_led <= 1'b0;
    end
    else
    begin
      inj_active_led <= cfg_q[CFG_RAND];
      for (int t = 0; t < 3; t++)
      begin
        // a fresh error restarts the flash; pause holds the light as it is
        if (!pause_q && inc[t] != 4'h0)
          flash_q[t] <= FLASH_CYC;
        else if (!pause_q && flash_q[t] != 32'h0000_0000)
          flash_q[t] <= flash_q[t] - 32'h0000_0001;
        led_q[t] <= flash_q[t] != 32'h0000_0000;
      end
      if (clr)
      begin
        for (int t = 0; t < 3; t++)
        begin
          tot_q[t] <= '0;
          es_q[t]  <= '0;
        end
        ovf_q      <= 3'h0;
        sec_err_q  <= 3'h0;
        sec_cnt_q  <= 32'h0000_0000;
        prbs_tot_q <= '0;
        b2_bits_q  <= 32'h0000_0000;
      end
      else if (cnt_en)
      begin
        sec_cnt_q <= sec_tick ? 32'h0000_0000 : sec_cnt_q + 32'h0000_0001;
        for (int t = 0; t < 3; t++)
        begin
          {ovf_q[t], tot_q[t]} <= {ovf_q[t], {CNT_W{1'b0}}} | sat_add(tot_q[t], inc[t]);
          if (sec_tick && (sec_err_q[t] || inc[t] != 4'h0))
            es_q[t] <= CNT_W'(sat_add(es_q[t], 4'h1));
          // an error in the tick cycle is charged to the closing second
          sec_err_q[t] <= sec_tick ? 1'b0 : (sec_err_q[t] | (inc[t] != 4'h0));
        end
        prbs_tot_q <= CNT_W'(sat_add(prbs_tot_q, prbs_inc));
        if (rx_chk && rx_pos_q == POS_W'(POS_B2))
          b2_bits_q <= b2_bits_q + B2_BITS_FRM;
      end
    end
  end

  assign b1_led    = led_q[0];
  assign b2_led    = led_q[1];
  assign rei_led   = led_q[2];
  assign run_led   = run_q;
  assign pause_led = pause_q;

  // read selection; unmapped words read zero
  wire [31:0] status_w = {22'h000000, locked_q, ovf_q, led_q, cfg_q[CFG_RAND], pause_q, run_q};
  wire [7:0]  rd_off   = {haddr[7:2], 2'b00};
  assign rd_mux =
    (rd_off == OFF_CFG)      ? cfg_q :
    (rd_off == OFF_TX_OH)    ? tx_oh_q :
    (rd_off == OFF_STATUS)   ? status_w :
    (rd_off == OFF_RX_OH1)   ? {8'h00, rx_oh1_q} :
    (rd_off == OFF_RX_OH2)   ? {8'h00, rx_oh2_q} :
    (rd_off == OFF_B1_TOT)   ? 32'(tot_q[0]) :
    (rd_off == OFF_B1_ES)    ? 32'(es_q[0]) :
    (rd_off == OFF_B2_TOT)   ? 32'(tot_q[1]) :
    (rd_off == OFF_B2_ES)    ? 32'(es_q[1]) :
    (rd_off == OFF_REI_TOT)  ? 32'(tot_q[2]) :
    (rd_off == OFF_REI_ES)   ? 32'(es_q[2]) :
    (rd_off == OFF_PRBS_TOT) ? 32'(prbs_tot_q) :
    (rd_off == OFF_B2_BITS)  ? b2_bits_q : 32'h0000_0000;
endmodule : smi_stm16_error_inject_monitor

// file: testbench/smi_ahb_monitor.sv
`timescale 1ns/1ps
module smi_ahb_monitor
  import smi_pkg::*;
#(
  parameter int unsigned FLASH_CYC = 50
) (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        link_clk,
  input wire logic [7:0]  tx_data,
  input wire logic        inj_active_led,
  input wire logic        b1_led,
  input wire logic        b2_led,
  input wire logic        run_led,
  input wire logic        pause_led
);
  logic        taken;
  logic        wr_cmd_q;
  logic        wr_cfg_q;
  logic        lk_q;
  logic [3:0]  since_q;
  logic [15:0] lit_q;

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // request decode; the data phase flags let a change be traced to its write
  assign taken = hsel && htrans[1] && hready;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_cmd_q <= 1'b0;
      wr_cfg_q <= 1'b0;
      lk_q     <= 1'b0;
      since_q  <= 4'hF;
      lit_q    <= 16'h0000;
    end
    else
    begin
      wr_cmd_q <= taken && hwrite && (haddr[7:0] == OFF_CMD);
      wr_cfg_q <= taken && hwrite && (haddr[7:0] == OFF_CFG);
      lk_q     <= link_clk;
      since_q  <= (link_clk && !lk_q) ? 4'h0 : ((since_q == 4'hF) ? since_q : since_q + 4'h1);
      lit_q    <= b2_led ? lit_q + 16'h0001 : 16'h0000; // saturation not needed at sim lengths
    end
  end

  hresp_okay_a: assert property (hresp == 1'b0) else $error("hresp not okay");
  ready_no_wait_a: assert property ($past(hresetn) |-> hreadyout) else $error("wait state inserted");
  rdata_hold_a: assert property (!$past(taken && !hwrite) |-> $stable(hrdata)) else $error("hrdata moved");
  tx_byte_slot_a: assert property ($changed(tx_data) |-> since_q <= 4'h6)
    else $error("tx byte changed outside its slot");
  run_cause_a: assert property ($changed(run_led) |-> $past(wr_cmd_q && hwdata[CMD_RUN_TGL]))
    else $error("run state changed without command");
  pause_cause_a: assert property ($changed(pause_led) |-> $past(wr_cmd_q && hwdata[CMD_PAUSE_TGL]))
    else $error("pause state changed without command");
  inj_cause_a: assert property ($changed(inj_active_led) |-> $past(wr_cfg_q) || $past(wr_cfg_q, 2))
    else $error("injection light changed without config write");
  b2_flash_len_a: assert property ($fell(b2_led) |-> lit_q >= FLASH_CYC - 1)
    else $error("b2 flash too short");
  b1_flash_hold_a: assert property ($rose(b1_led) |-> b1_led [*8])
    else $error("b1 flash dropped early");

  cover property ($rose(run_led));
  cover property ($rose(b2_led));
  cover property ($rose(inj_active_led));
endmodule : smi_ahb_monitor

bind smi_stm16_error_inject_monitor smi_ahb_monitor #(.FLASH_CYC(FLASH_CYC)) u_mon (.*);

// file: testbench/smi_line_model.sv
`timescale 1ns/1ps
// optical line looped back: one byte of delay, free-running line clock
module smi_line_model (
  output logic            link_clk,
  input  wire logic [7:0] tx_data,
  output logic      [7:0] rx_data
);
  // odd start offset puts every line clock edge 3 ns ahead of an hclk rising edge, never on one
  initial
  begin
    link_clk = 1'b0;
    #7;
    forever #80 link_clk = ~link_clk;
  end

  // byte taken at the slot edge, when the sender's byte has long settled
  always @(posedge link_clk)
  begin
    rx_data <= tx_data;
  end
endmodule : smi_line_model

// file: testbench/stm16_error_inject_monitor_test.sv
`timescale 1ns/1ps
module stm16_error_inject_monitor_test;
  import smi_pkg::*;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  wire  [31:0] hrdata;
  wire         hreadyout;
  wire         hresp;
  wire         link_clk;
  wire  [7:0]  rx_data;
  wire  [7:0]  tx_data;
  wire         inj_led;
  wire  [2:0]  leds;
  wire         run_led;
  wire         pause_led;
  logic [2:0]  prv = 3'h0;
  int          fl [3];
  int          failures;
  int          total_checks;
  logic [31:0] v;
  logic [31:0] t;

  smi_stm16_error_inject_monitor #(.FRAME_LEN(64), .CNT_W(8), .ES_CYC(8000), .FLASH_CYC(2000)) u_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .link_clk(link_clk), .rx_data(rx_data), .tx_data(tx_data),
    .inj_active_led(inj_led), .b1_led(leds[0]), .b2_led(leds[1]), .rei_led(leds[2]),
    .run_led(run_led), .pause_led(pause_led));
  smi_line_model u_line (.link_clk(link_clk), .tx_data(tx_data), .rx_data(rx_data));

  initial
  begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end

  // count flashes of each error light
  always @(posedge hclk)
  begin
    prv <= leds;
    for (int i = 0; i < 3; i++)
      if (leds[i] && !prv[i])
        fl[i] <= fl[i] + 1;
  end

  task conclude;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : conclude

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task idle(input int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask : idle

  // one single transfer: address phase held until hready, then data phase until hready
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    hwrite <= w;
    htrans <= 2'b10;
    n = 0;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
    htrans <= 2'b00;
    hwdata <= d;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 100);
    r = hrdata;
    if (n >= 100)
    begin
      failures++;
      conclude();
    end
  endtask : bus

  // a spare cycle after each write keeps a following read of it clean
  task wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, t);
    idle(1);
  endtask : wr

  task rdc(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000, v);
    chk(v, exp);
  endtask : rdc

  // two single injections of one kind, then light, total and errored seconds
  task ptest(input int b, input logic [7:0] a, input logic [31:0] et, input logic [31:0] em);
    int f0;
    f0 = fl[b];
    repeat (2)
    begin
      wr(OFF_CMD, 32'h1 << (CMD_INJ_B1 + b));
      idle(2500);
    end
    chk(32'(fl[b] - f0), 32'h2);
    rdc(a, et);
    // errored seconds only move at a tick, so let one interval (ES_CYC) pass
    idle(8000);
    bus(1'b0, a + 8'h04, 32'h0, v);
    chk(32'(v >= 1 && v <= em), 32'h1);
  endtask : ptest

  initial
  begin
    {hsel, haddr, htrans, hwrite, hwdata} = '0;
    hsize   = 3'b010;
    hresetn = 1'b0;
    idle(6);
    hresetn = 1'b1;
    idle(2);
    rdc(8'h38, 32'h0);
    rdc(OFF_CMD, 32'h0);
    wr(OFF_TX_OH, 32'h0511_AA51);
    wr(OFF_CFG, 32'h0000_0007);
    idle(2000);
    rdc(OFF_RX_OH1, 32'h0051_28F6);
    rdc(OFF_RX_OH2, 32'h0005_11AA);
    wr(OFF_CMD, 32'h1 << CMD_INJ_B1);
    idle(2500);
    rdc(OFF_B1_TOT, 32'h0);
    wr(OFF_CMD, 32'h1);
    ptest(0, OFF_B1_TOT, 32'h2, 32'h2);
    ptest(1, OFF_B2_TOT, 32'h4, 32'h4);
    ptest(2, OFF_REI_TOT, 32'h2, 32'h2);
    rdc(OFF_PRBS_TOT, 32'h0);
    // restart by two toggles
    wr(OFF_CMD, 32'h1);
    wr(OFF_CMD, 32'h1);
    for (int i = 0; i < 6; i++)
      rdc(OFF_B1_TOT + 8'(4 * i), 32'h0);
    bus(1'b0, OFF_STATUS, 32'h0, v);
    chk(v & 32'h3, 32'h1);
    chk(32'(run_led), 32'h1);
    // pause freezes, resume counts again
    wr(OFF_CMD, 32'h1 << CMD_PAUSE_TGL);
    chk(32'(pause_led), 32'h1);
    wr(OFF_CMD, 32'h1 << CMD_INJ_B1);
    idle(2500);
    rdc(OFF_B1_TOT, 32'h0);
    wr(OFF_CMD, 32'h1 << CMD_PAUSE_TGL);
    wr(OFF_CMD, 32'h1 << CMD_INJ_B1);
    idle(2500);
    rdc(OFF_B1_TOT, 32'h1);
    // random errors at 1e-3, measured after a restart
    wr(OFF_CFG, 32'h0000_000F);
    idle(4);
    chk(32'(inj_led), 32'h1);
    wr(OFF_CMD, 32'h1);
    wr(OFF_CMD, 32'h1);
    idle(20000);
    bus(1'b0, OFF_B2_TOT, 32'h0, t);
    bus(1'b0, OFF_B2_BITS, 32'h0, v);
    chk(32'(t != 0 && t * 500 <= v && v <= t * 2000), 32'h1);
    bus(1'b0, OFF_B1_TOT, 32'h0, t);
    bus(1'b0, OFF_STATUS, 32'h0, v);
    chk(32'(v[6]), 32'(t == 32'hFF));
    wr(OFF_CFG, 32'h0000_0003);
    idle(4);
    chk(32'(inj_led), 32'h0);
    idle(4000);
    chk(32'(leds), 32'h0);
    bus(1'b0, OFF_B2_TOT, 32'h0, t);
    idle(3000);
    rdc(OFF_B2_TOT, t);
    // pass mode J0 and cleared D bytes
    wr(OFF_TX_OH, 32'h0);
    idle(2000);
    rdc(OFF_RX_OH1, 32'h0001_28F6);
    rdc(OFF_RX_OH2, 32'h0);
    conclude();
  end
endmodule : stm16_error_inject_monitor_test
